//--- verilog/erbc_pkg.sv
// package for the error recovery budget controller
// assumes a single 100 MHz clock and a classic wishbone register bus
package erbc_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_US         = 1000;

    // recovery levels and retry limits
    localparam logic [3:0] READ_LEVELS     = 4'hd;
    localparam logic [3:0] WRITE_LEVELS    = 4'h5;
    localparam logic [3:0] READ_RETRY_MAX  = 4'hb;
    localparam logic [2:0] WRITE_RETRY_MAX = 3'h5;

    // per block ceilings, microseconds, indexed by retry count
    localparam logic [20:0] READ_CEIL_US [0:11] = '{
        21'd51870,  21'd59850,  21'd203490, 21'd231420,
        21'd295260, 21'd327180, 21'd359100, 21'd446880,
        21'd538650, 21'd570570, 21'd598500, 21'd1534970};
    localparam logic [20:0] WRITE_CEIL_US [0:5] = '{
        21'd23940, 21'd35910, 21'd39900,
        21'd51870, 21'd79800, 21'd107730};

    localparam logic [15:0] TLIMIT_DEFAULT = 16'hffff;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_RETRY    = 8'h04;
    localparam logic [7:0] REG_TLIMIT   = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam logic [7:0] REG_DEF_SEL  = 8'h18;
    localparam logic [7:0] REG_DEF_DATA = 8'h1c;
    localparam logic [7:0] REG_BUDGET   = 8'h20;

    // control fields
    localparam int         CTRL_RECOV_EN = 0;
    localparam int         CTRL_AUTO_RD  = 1;
    localparam int         CTRL_AUTO_WR  = 2;
    localparam int         CTRL_RDO      = 3;
    localparam logic [3:0] CTRL_RST      = 4'h7;

    // retry fields
    localparam int         RETRY_RD_LSB = 0;
    localparam int         RETRY_WR_LSB = 8;
    localparam logic [3:0] RETRY_RD_RST = 4'hb;
    localparam logic [2:0] RETRY_WR_RST = 3'h5;

    // interrupt status / mask bits
    localparam int IRQ_RECOVERED = 0;
    localparam int IRQ_UNRECOV   = 1;
    localparam int IRQ_REALLOC   = 2;
    localparam int IRQ_BUDGET    = 3;
    localparam int IRQ_W         = 4;

    // status fields
    localparam int STAT_LEVEL_LSB = 4;
    localparam int STAT_ACTIVE    = 8;
    localparam int STAT_BUDGET    = 9;
    localparam int STAT_FAILED    = 10;
    localparam int STAT_GROWN_LSB = 16;

    localparam int DEF_SEL_GROWN = 7;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ACTIVE  = 3'b001,
        ST_ISSUE   = 3'b010,
        ST_WAIT    = 3'b011,
        ST_REALLOC = 3'b100,
        ST_REWAIT  = 3'b101
    } erbc_state_t;

    typedef struct packed {
        logic        write;
        logic [3:0]  level;
        logic [31:0] lba;
    } erbc_step_t;

endpackage : erbc_pkg

//--- verilog/erbc_recovery_ctrl.sv
// error recovery budget controller: retry levels, time budget,
// reallocation decision, factory and grown defect lists
// assumes one clock, synchronous inputs, classic wishbone slave
//
// What this block does
// - thirteen read levels, five write levels
// - each step is one re-read or re-write
// - retry count sets highest level reached
// - recover only when enabled, per stored options
// - per-block and per-command effort bounded separately
// - read retry 0..11 maps to block ceilings
// - write retry 0..5 maps to block ceilings
// - retry count zero skips recovery
// - reallocate only if enabled, flag clear, budget left
// - reallocation time not charged to budget
// - recovered-data-only flag suppresses all reallocation
// - flag set means no unrecovered error reports
// - sixteen-bit millisecond command budget
// - budget counts only during recovery, restarts per command
// - zero budget means 0xffff
// - budget of one is smallest effective value
// - factory list fixed, grown list separate, both readable
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module erbc_recovery_ctrl
    import erbc_pkg::*;
#(
    parameter int US_TICK         = US_CYCLES,
    parameter int MS_TICK         = MS_US,
    parameter int STEPS_PER_LEVEL = 2,
    parameter int GROWN_DEPTH     = 8,
    parameter int FACTORY_DEPTH   = 4
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // command framing
    input  wire logic        cmdStart,
    input  wire logic        cmdWrite,
    input  wire logic        cmdEnd,
    input  wire logic        factoryFormat,
    // failing block report from the media path
    input  wire logic        blkFail,
    input  wire logic [31:0] blkLba,
    // recovery attempts
    output logic             stepValid,
    output erbc_step_t       stepOut,
    input  wire logic        stepDone,
    input  wire logic        stepOk,
    // reallocation
    output logic             reallocValid,
    output logic      [31:0] reallocLba,
    input  wire logic        reallocDone,
    // results
    output logic             blkResolved,
    output logic             blkRecovered,
    output logic             errReport,
    output logic             cmdFailed,
    output logic             budgetOut,
    output logic             irq
);

    function automatic logic [31:0] wbMerge(input logic [31:0] old,
                                            input logic [31:0] din,
                                            input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction : wbMerge

    function automatic logic [3:0] maxLevelOf(input logic       wr,
                                              input logic [3:0] rd,
                                              input logic [2:0] wrc);
        if (wr) begin
            maxLevelOf = (wrc >= WRITE_RETRY_MAX) ? WRITE_LEVELS : {1'b0, wrc};
        end else begin
            maxLevelOf = (rd >= READ_RETRY_MAX) ? READ_LEVELS : rd + 4'h1;
        end
    endfunction : maxLevelOf

    erbc_state_t state, next_state;
    logic [3:0]  ctrl;
    logic [3:0]  rdRetry;
    logic [2:0]  wrRetry;
    logic [15:0] tlimit;
    logic [IRQ_W-1:0] intStat, intMask, intEvt;
    logic [7:0]  defSel;
    logic [FACTORY_DEPTH-1:0][31:0] factoryList;
    logic [GROWN_DEPTH-1:0][31:0]   grownList;
    logic [7:0]  grownCount;
    logic        isWrite;
    logic [3:0]  level;
    logic [7:0]  stepCnt;
    logic [31:0] failLba;
    logic [15:0] usPre;
    logic [9:0]  msSub;
    logic [15:0] budgetMs;
    logic [20:0] blkUs;
    logic        wbHit, wbWr, wbRd;
    logic        recovering, usTick;
    logic [15:0] effLimit;
    logic [3:0]  curRetry, maxLevel;
    logic [20:0] ceiling;
    logic        reallocOk, next_giveUp, next_recovered, next_doRealloc;
    logic        blkStart;

    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr  = wbHit && wb_we_i;
    assign wbRd  = wbHit && !wb_we_i;

    assign recovering = (state == ST_ISSUE) || (state == ST_WAIT);
    assign usTick     = (usPre == 16'(US_TICK - 1));
    assign effLimit   = (tlimit == 16'h0000) ? TLIMIT_DEFAULT : tlimit;
    assign budgetOut  = (budgetMs >= effLimit);
    assign curRetry   = isWrite ? {1'b0, wrRetry} : rdRetry;
    assign maxLevel   = maxLevelOf(isWrite, rdRetry, wrRetry);
    assign ceiling    = isWrite
        ? WRITE_CEIL_US[(wrRetry > WRITE_RETRY_MAX) ? WRITE_RETRY_MAX : wrRetry]
        : READ_CEIL_US[(rdRetry > READ_RETRY_MAX) ? READ_RETRY_MAX : rdRetry];
    assign reallocOk  = (isWrite ? ctrl[CTRL_AUTO_WR] : ctrl[CTRL_AUTO_RD])
                        && !ctrl[CTRL_RDO] && !budgetOut
                        && (grownCount < 8'(GROWN_DEPTH));
    assign blkStart   = (state == ST_ACTIVE) && blkFail && !cmdEnd;

    assign stepValid    = (state == ST_ISSUE);
    assign reallocValid = (state == ST_REALLOC);
    assign irq          = |(intStat & intMask);

    // recovery sequencer
    always_comb begin
        next_state     = state;
        next_giveUp    = 1'b0;
        next_recovered = 1'b0;
        next_doRealloc = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (cmdStart) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (cmdEnd) begin
                    next_state = ST_IDLE;
                end else if (blkFail) begin
                    if (!ctrl[CTRL_RECOV_EN] || curRetry == 4'h0
                        || budgetOut) begin
                        next_giveUp    = 1'b1;
                        next_doRealloc = reallocOk;
                    end else begin
                        next_state = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: next_state = ST_WAIT;
            ST_WAIT: begin
                if (budgetOut) begin
                    next_giveUp = 1'b1;
                end else if (blkUs >= ceiling) begin
                    next_giveUp    = 1'b1;
                    next_doRealloc = reallocOk;
                end else if (stepDone && stepOk) begin
                    next_recovered = 1'b1;
                    next_state     = ST_ACTIVE;
                end else if (stepDone) begin
                    if (stepCnt + 8'h1 < 8'(STEPS_PER_LEVEL)
                        || level < maxLevel) begin
                        next_state = ST_ISSUE;
                    end else begin
                        next_giveUp    = 1'b1;
                        next_doRealloc = reallocOk;
                    end
                end
                if (next_giveUp) begin
                    next_state = next_doRealloc ? ST_REALLOC : ST_ACTIVE;
                end
            end
            ST_REALLOC: next_state = ST_REWAIT;
            ST_REWAIT: begin
                if (reallocDone) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (state == ST_ACTIVE && next_giveUp) begin
            next_state = next_doRealloc ? ST_REALLOC : ST_ACTIVE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // command context and level/step walk
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            isWrite <= 1'b0;
            level   <= 4'h0;
            stepCnt <= 8'h00;
            failLba <= 32'h0000_0000;
        end else begin
            if (state == ST_IDLE && cmdStart) begin
                isWrite <= cmdWrite;
            end
            if (blkStart) begin
                failLba <= blkLba;
                level   <= 4'h1;
                stepCnt <= 8'h00;
            end else if (state == ST_WAIT && stepDone && !stepOk
                         && next_state == ST_ISSUE) begin
                if (stepCnt + 8'h1 < 8'(STEPS_PER_LEVEL)) begin
                    stepCnt <= stepCnt + 8'h1;
                end else begin
                    stepCnt <= 8'h00;
                    level   <= level + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stepOut    <= '0;
            reallocLba <= 32'h0000_0000;
        end else begin
            stepOut.write <= isWrite;
            stepOut.level <= (next_state == ST_ISSUE && state == ST_WAIT
                              && stepCnt + 8'h1 >= 8'(STEPS_PER_LEVEL))
                             ? level + 4'h1
                             : (blkStart ? 4'h1 : level);
            stepOut.lba   <= blkStart ? blkLba : failLba;
            reallocLba    <= failLba;
        end
    end

    // microsecond prescaler, budget and per-block timers
    always_ff @(posedge ref_clk) begin
        if (!rst_n || usTick) begin
            usPre <= 16'h0000;
        end else begin
            usPre <= usPre + 16'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || (state == ST_IDLE && cmdStart)) begin
            msSub    <= 10'h000;
            budgetMs <= 16'h0000;
        end else if (recovering && usTick) begin
            if (msSub == 10'(MS_TICK - 1)) begin
                msSub <= 10'h000;
                if (budgetMs != 16'hffff) begin
                    budgetMs <= budgetMs + 16'h1;
                end
            end else begin
                msSub <= msSub + 10'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || blkStart) begin
            blkUs <= 21'h000000;
        end else if (recovering && usTick && blkUs != 21'h1fffff) begin
            blkUs <= blkUs + 21'h1;
        end
    end

    // block outcome and error reporting
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blkResolved  <= 1'b0;
            blkRecovered <= 1'b0;
            errReport    <= 1'b0;
            cmdFailed    <= 1'b0;
        end else begin
            blkResolved  <= next_giveUp || next_recovered;
            blkRecovered <= next_recovered;
            errReport    <= next_giveUp && !ctrl[CTRL_RDO];
            if (state == ST_IDLE && cmdStart) begin
                cmdFailed <= 1'b0;
            end else if (next_giveUp && !ctrl[CTRL_RDO]) begin
                cmdFailed <= 1'b1;
            end
        end
    end

    // defect lists
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            grownCount <= 8'h00;
            grownList  <= '0;
        end else if (state == ST_REWAIT && reallocDone) begin
            grownList[grownCount[$clog2(GROWN_DEPTH)-1:0]] <= failLba;
            grownCount <= grownCount + 8'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            factoryList <= '0;
        end else if (wbWr && wb_adr_i == REG_DEF_DATA && factoryFormat
                     && !defSel[DEF_SEL_GROWN]) begin
            factoryList[defSel[$clog2(FACTORY_DEPTH)-1:0]] <=
                wbMerge(factoryList[defSel[$clog2(FACTORY_DEPTH)-1:0]],
                        wb_dat_i, wb_sel_i);
        end
    end

    // software registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl    <= CTRL_RST;
            rdRetry <= RETRY_RD_RST;
            wrRetry <= RETRY_WR_RST;
            tlimit  <= TLIMIT_DEFAULT;
            intMask <= '0;
            defSel  <= 8'h00;
        end else if (wbWr) begin
            unique case (wb_adr_i)
                REG_CTRL: ctrl <= 4'(wbMerge({28'h0, ctrl}, wb_dat_i,
                                             wb_sel_i));
                REG_RETRY: begin
                    rdRetry <= wb_sel_i[0] ? wb_dat_i[RETRY_RD_LSB +: 4]
                                           : rdRetry;
                    wrRetry <= wb_sel_i[1] ? wb_dat_i[RETRY_WR_LSB +: 3]
                                           : wrRetry;
                end
                REG_TLIMIT: tlimit <= 16'(wbMerge({16'h0, tlimit}, wb_dat_i,
                                                  wb_sel_i));
                REG_INT_MASK: intMask <= wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0]
                                                     : intMask;
                REG_DEF_SEL: defSel <= wb_sel_i[0] ? wb_dat_i[7:0] : defSel;
                default: ;
            endcase
        end
    end

    // sticky events, read to clear, set wins
    assign intEvt[IRQ_RECOVERED] = next_recovered;
    assign intEvt[IRQ_UNRECOV]   = next_giveUp && !ctrl[CTRL_RDO];
    assign intEvt[IRQ_REALLOC]   = (state == ST_REWAIT) && reallocDone;
    assign intEvt[IRQ_BUDGET]    = recovering && budgetOut;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            intStat <= '0;
        end else if (wbRd && wb_adr_i == REG_INT_STAT) begin
            intStat <= intEvt;
        end else begin
            intStat <= intStat | intEvt;
        end
    end

    // bus answer: one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= 32'h0000_0000;
            if (wbRd) begin
                unique case (wb_adr_i)
                    REG_CTRL:     wb_dat_o <= {28'h0, ctrl};
                    REG_RETRY:    wb_dat_o <= {21'h0, wrRetry, 4'h0, rdRetry};
                    REG_TLIMIT:   wb_dat_o <= {16'h0, tlimit};
                    REG_STATUS: begin
                        wb_dat_o[2:0]                 <= state;
                        wb_dat_o[STAT_LEVEL_LSB +: 4] <= level;
                        wb_dat_o[STAT_ACTIVE]         <= (state != ST_IDLE);
                        wb_dat_o[STAT_BUDGET]         <= budgetOut;
                        wb_dat_o[STAT_FAILED]         <= cmdFailed;
                        wb_dat_o[STAT_GROWN_LSB +: 8] <= grownCount;
                    end
                    REG_INT_STAT: wb_dat_o <= {28'h0, intStat};
                    REG_INT_MASK: wb_dat_o <= {28'h0, intMask};
                    REG_DEF_SEL:  wb_dat_o <= {24'h0, defSel};
                    REG_DEF_DATA: wb_dat_o <= defSel[DEF_SEL_GROWN]
                        ? grownList[defSel[$clog2(GROWN_DEPTH)-1:0]]
                        : factoryList[defSel[$clog2(FACTORY_DEPTH)-1:0]];
                    REG_BUDGET:   wb_dat_o <= {16'h0, budgetMs};
                    default: ;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_realloc_hs;
        reallocValid ##1 (state == ST_REWAIT);
    endsequence

    sequence s_expire;
        (state == ST_WAIT) && budgetOut;
    endsequence

    a_step_single: assert property (stepValid |=> !stepValid)
        else $error("recovery step request held two cycles");
    a_step_level: assert property (
        stepValid |-> stepOut.level >= 4'h1 && stepOut.level <= maxLevel)
        else $error("recovery step beyond allowed level");
    a_zero_skip: assert property (
        blkStart && curRetry == 4'h0 |=> !stepValid ##1 !stepValid)
        else $error("recovery started with retry count zero");
    a_expire_stop: assert property (
        s_expire |=> state == ST_ACTIVE ##1 !reallocValid)
        else $error("recovery continued after budget expiry");
    a_realloc_gate: assert property (
        s_realloc_hs |-> $past(!ctrl[CTRL_RDO], 2) && $past(!budgetOut, 2))
        else $error("reallocation without permission");
    a_budget_frozen: assert property (
        state inside {ST_REALLOC, ST_REWAIT, ST_ACTIVE} |=> $stable(budgetMs))
        else $error("budget advanced outside recovery");
    a_budget_restart: assert property (
        state == ST_IDLE && cmdStart |=> budgetMs == 16'h0000 && !cmdFailed)
        else $error("budget not restarted on new command");
    a_quiet_report: assert property (
        errReport |-> $past(!ctrl[CTRL_RDO]))
        else $error("unrecovered error reported with flag set");
    a_factory_fixed: assert property (
        !factoryFormat |=> $stable(factoryList))
        else $error("factory defect table changed");

endmodule : erbc_recovery_ctrl

//--- tb/erbc_media_model.sv
// media path stand-in answering re-read, re-write and realloc pulses
// assumes the controller raises each request for one ref_clk cycle
`timescale 1ns/100ps
module erbc_media_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // bench controls
    input  wire logic       blkFail,
    input  wire logic [7:0] okAt,
    input  wire logic [7:0] dly,
    // controller side
    input  wire logic       stepValid,
    input  wire logic       reallocValid,
    output logic            stepDone,
    output logic            stepOk,
    output logic            reallocDone
);
    logic [7:0] n;
    logic [7:0] t;
    logic       pend;
    logic       rel;

    // one answer per request, dly+2 cycles after it; okAt 0 never recovers
    always @(posedge ref_clk) begin
        stepDone    <= 1'b0;
        reallocDone <= 1'b0;
        stepOk      <= ~stepOk;
        if (!rst_n) begin
            pend   <= 1'b0;
            n      <= 8'h0;
            stepOk <= 1'b0;
        end else if (blkFail) begin
            n <= 8'h0;
        end else if (stepValid || reallocValid) begin
            pend <= 1'b1;
            rel  <= reallocValid;
            t    <= dly;
            n    <= n + {7'h0, stepValid};
        end else if (pend && t == 8'h0) begin
            pend        <= 1'b0;
            stepDone    <= ~rel;
            reallocDone <= rel;
            stepOk      <= ~rel && n == okAt;
        end else if (pend) begin
            t <= t - 8'h1;
        end
    end
endmodule : erbc_media_model

//--- tb/tb_erbc_recovery_ctrl.sv
// bench for the recovery controller: bus tasks, block runs, counts
// assumes erbc_media_model answers the step and realloc pulses
`timescale 1ns/100ps
module tb_erbc_recovery_ctrl
    import erbc_pkg::*;
;
    logic        ref_clk = 0, rst_n = 0, cyc = 0, we = 0, w = 0, rec;
    logic        cmdStart = 0, cmdWrite = 0, cmdEnd = 0, blkFail = 0;
    logic        fmt = 0, fail;
    logic        stepValid, stepDone, stepOk, reallocValid, reallocDone;
    logic        blkResolved, blkRecovered, errReport, budgetOut, irq, ack;
    logic [7:0]  adr = 0, okAt = 0, dly = 8'h2;
    logic [31:0] dat = 0, rdat, q, blkLba = 0, reallocLba, lba = 32'h91d9;
    logic [3:0]  lvl;
    erbc_step_t  stepOut;
    int          errorCnt = 0, nTests = 0, nSteps, nRel, nErr, rd, wr;

    always #5 ref_clk = ~ref_clk;

    erbc_recovery_ctrl #(.US_TICK(1), .MS_TICK(4)) u_erbc_recovery_ctrl (
        .ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cmdStart, .cmdWrite, .cmdEnd, .factoryFormat(fmt),
        .blkFail, .blkLba, .stepValid, .stepOut, .stepDone, .stepOk,
        .reallocValid, .reallocLba, .reallocDone, .blkResolved,
        .blkRecovered, .errReport, .cmdFailed(fail), .budgetOut, .irq);
    erbc_media_model u_erbc_media_model (.ref_clk, .rst_n, .blkFail,
        .okAt, .dly, .stepValid, .reallocValid, .stepDone, .stepOk,
        .reallocDone);

    function logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
            errorCnt++;
        end
    endtask : chk

    task stopTest;
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stopTest

    task wb(input logic wv, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        we  <= wv;
        adr <= a;
        dat <= d;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask : wb

    // ex = {recovered, reallocated, error reported}
    task blk(input logic wv, input logic [7:0] ok, input int st,
             input logic [2:0] ex);
        lba = nxt(lba);
        w = wv;
        nSteps = 0;
        nRel = 0;
        nErr = 0;
        okAt <= ok;
        @(posedge ref_clk);
        cmdStart <= 1'b1;
        cmdWrite <= wv;
        @(posedge ref_clk);
        cmdStart <= 1'b0;
        blkFail  <= 1'b1;
        blkLba   <= lba;
        @(posedge ref_clk);
        blkFail <= 1'b0;
        do begin
            @(posedge ref_clk);
        end while (blkResolved !== 1'b1);
        rec = blkRecovered;
        repeat (30) @(posedge ref_clk);
        cmdEnd <= 1'b1;
        @(posedge ref_clk);
        cmdEnd <= 1'b0;
        chk(32'(nSteps), 32'(st));
        chk({28'h0, fail, rec, nRel[0], nErr[0]}, {28'h0, ex[0], ex});
        $display("block write=%0d steps=%0d done", wv, nSteps);
    endtask : blk

    always @(posedge ref_clk) begin
        if (stepValid) begin
            if (nSteps == 0) chk({28'h0, stepOut.level}, 32'h1);
            chk({stepOut.write, stepOut.lba[30:0]}, {w, lba[30:0]});
            lvl = stepOut.level;
            nSteps++;
        end
        if (reallocValid) chk(reallocLba, lba);
        nRel += int'(reallocValid);
        nErr += int'(errReport);
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        errorCnt++;
        stopTest();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        wb(1'b0, REG_CTRL, 0);
        chk(q, 32'h7);
        wb(1'b0, REG_RETRY, 0);
        chk(q, 32'h50b);
        wb(1'b0, REG_TLIMIT, 0);
        chk(q, 32'hffff);
        wb(1'b0, 8'h3c, 0);
        chk(q, 32'h0);
        wb(1'b1, REG_INT_MASK, 32'hf);
        for (int i = 0; i < 6; i++) begin
            lba = nxt(lba);
            rd = (i == 0) ? 11 : int'(lba % 11) + 1;
            wr = int'(lba % 5) + 1;
            dly <= {6'h0, lba[4:3]} + 8'h1;
            wb(1'b1, REG_RETRY, {21'h0, 3'(wr), 4'h0, 4'(rd)});
            blk(i[0], 8'h0, i[0] ? 2 * wr : 2 * rd + 2 + 2 * (rd / 11), 3'b011);
            chk({28'h0, lvl}, 32'(i[0] ? wr : rd + 1 + rd / 11));
            wb(1'b0, REG_STATUS, 0);
            chk({24'h0, q[23:16]}, 32'(i + 1));
            wb(1'b1, REG_DEF_SEL, 32'h80 + i);
            wb(1'b0, REG_DEF_DATA, 0);
            chk(q, lba);
            chk({31'h0, irq}, 32'h1);
            wb(1'b0, REG_INT_STAT, 0);
            chk(q, 32'h6);
        end
        fmt <= 1'b1;
        wb(1'b1, REG_DEF_SEL, 32'h1);
        wb(1'b1, REG_DEF_DATA, lba);
        fmt <= 1'b0;
        wb(1'b1, REG_DEF_DATA, 32'h0);
        wb(1'b0, REG_DEF_DATA, 0);
        chk(q, lba);
        blk(1'b0, 8'h3, 3, 3'b100);
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b1, REG_RETRY, 32'h0);
        blk(1'b0, 8'h0, 0, 3'b001);
        wb(1'b1, REG_CTRL, 32'h0);
        wb(1'b1, REG_RETRY, 32'h50b);
        blk(1'b1, 8'h0, 0, 3'b001);
        wb(1'b1, REG_CTRL, 32'hf);
        wb(1'b1, REG_RETRY, 32'h501);
        blk(1'b0, 8'h0, 4, 3'b000);
        wb(1'b1, REG_CTRL, 32'h7);
        wb(1'b1, REG_TLIMIT, 32'h10001);
        wb(1'b0, REG_TLIMIT, 0);
        chk(q, 32'h1);
        dly <= 8'd20;
        repeat (2) blk(1'b0, 8'h0, 1, 3'b001);
        chk({31'h0, budgetOut}, 32'h1);
        wb(1'b0, REG_INT_STAT, 0);
        chk(q & 32'hc, 32'h8);
        wb(1'b1, REG_TLIMIT, 32'h0);
        blk(1'b0, 8'h0, 4, 3'b011);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, REG_INT_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        stopTest();
    end
endmodule : tb_erbc_recovery_ctrl
